// [spd_map.svh]
// constants for the serial power driver shift logic
// assumes inclusion by bare name from every design file that needs offsets
`ifndef SPD_MAP_SVH
`define SPD_MAP_SVH
`define SPD_CHANNELS 8
`define SPD_CFG_OFFSET 1'h0
`define SPD_FAULT_OFFSET 1'h1
`define SPD_CFG_RESET 8'h00
`define SPD_FAULT_RESET 24'h000000
`define SPD_FAULT_BITS 24
`define SPD_FAULT_OC_MSB 23
`define SPD_FAULT_OC_LSB 16
`define SPD_FAULT_OS_MSB 15
`define SPD_FAULT_OS_LSB 8
`define SPD_FAULT_RSV_BIT 7
`define SPD_FAULT_TH_BIT 6
`define SPD_FAULT_CRC_MSB 5
`define SPD_CRC_BITS 6
`define SPD_CRC_POLY 7'h43
`define SPD_CNT_BITS 5
`define SPD_FAULT_LAST 5'h18
`endif

// [spd_pkg.sv]
// types and helper functions for the serial power driver shift logic
// assumes spd_map.svh is on the include path
`include "spd_map.svh"
package spd_pkg;
  typedef logic [`SPD_CHANNELS-1:0] spd_chan_t;
  typedef logic [`SPD_CNT_BITS-1:0] spd_cnt_t;
  typedef logic [`SPD_CRC_BITS-1:0] spd_crc_t;
  typedef logic [`SPD_FAULT_BITS-1:0] spd_word_t;

  // long division of {cfg, six zeros} by the 7-bit polynomial
  function automatic spd_crc_t spd_crc(input spd_chan_t cfg);
    logic [13:0] rem;
    rem = {cfg, 6'h00};
    for (int i = 13; i >= `SPD_CRC_BITS; i--)
    begin
      if (rem[i])
      begin
        rem[i -: 7] = rem[i -: 7] ^ `SPD_CRC_POLY;
      end
    end
    return rem[`SPD_CRC_BITS-1:0];
  endfunction

  function automatic spd_cnt_t spd_gray2bin(input spd_cnt_t g);
    spd_cnt_t b;
    b[`SPD_CNT_BITS-1] = g[`SPD_CNT_BITS-1];
    for (int i = `SPD_CNT_BITS-2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction
endpackage

// [spd_sync.sv]
// two-flop synchroniser for a group of levels
// assumes each bit is a level, or a word held stable longer than two clocks
`timescale 1ns/10ps
`default_nettype none
module spd_sync
  import spd_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // levels in and out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  always_comb
  begin
    next_meta = i_async;
    next_sync = meta;
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta <= next_meta;
      o_sync <= next_sync;
    end
  end
endmodule
`default_nettype wire

// [spd_link.sv]
// shift-clock domain: input shift register, cascade bit, falling edge count
// assumes the shift clock may stop between frames; nothing here needs it to run
`timescale 1ns/10ps
`default_nettype none
`include "spd_map.svh"
module spd_link
  import spd_pkg::*;
(
  // link clock and reset
  input wire logic i_shift_clock,
  input wire logic i_link_nrst,
  // serial data
  input wire logic i_serial_in,
  // toward the system domain
  output spd_chan_t o_shift_word,
  output logic o_cascade_bit,
  output spd_cnt_t o_fall_gray
);
  spd_chan_t next_shift_word;
  logic next_cascade_bit;
  spd_cnt_t fall_bin;
  spd_cnt_t next_fall_bin;
  spd_cnt_t next_fall_gray;

  always_comb
  begin
    next_shift_word = {o_shift_word[`SPD_CHANNELS-2:0], i_serial_in};
    next_cascade_bit = o_shift_word[`SPD_CHANNELS-1];
    next_fall_bin = fall_bin + 5'h01;
    next_fall_gray = next_fall_bin ^ (next_fall_bin >> 1);
  end

  always_ff @(posedge i_shift_clock or negedge i_link_nrst)
  begin
    if (!i_link_nrst)
    begin
      o_shift_word <= `SPD_CFG_RESET;
    end
    else
    begin
      o_shift_word <= next_shift_word;
    end
  end

  // gray count lets the system domain follow falling edges safely
  always_ff @(negedge i_shift_clock or negedge i_link_nrst)
  begin
    if (!i_link_nrst)
    begin
      o_cascade_bit <= 1'b0;
      fall_bin <= '0;
      o_fall_gray <= '0;
    end
    else
    begin
      o_cascade_bit <= next_cascade_bit;
      fall_bin <= next_fall_bin;
      o_fall_gray <= next_fall_gray;
    end
  end
endmodule
`default_nettype wire

// [spd_top.sv]
// serial power driver shift logic: storage, output buffers, faults, readback
// assumes host pins are asynchronous to i_clock; the shift clock is the link clock
`timescale 1ns/10ps
`default_nettype none
`include "spd_map.svh"
module spd_top
  import spd_pkg::*;
(
  // system clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // serial link from the host
  input wire logic i_shift_clock,
  input wire logic i_serial_in,
  input wire logic i_latch_clock,
  input wire logic i_clear_all_n,
  input wire logic i_output_enable_n,
  output logic o_serial_out,
  // power channels
  output spd_chan_t o_sink_channel_outputs,
  output spd_chan_t o_chop_active,
  // analog sense comparators
  input wire logic [`SPD_CHANNELS-1:0] i_overcurrent,
  input wire logic [`SPD_CHANNELS-1:0] i_below_load_detect,
  input wire logic i_temp_over_trip,
  input wire logic i_temp_below_release
);
  // link domain
  logic link_nrst;
  spd_chan_t shift_word;
  logic cascade_bit;
  spd_cnt_t fall_gray;

  // synchronised views
  spd_chan_t shift_word_q;
  logic cascade_q;
  spd_cnt_t fall_gray_q;
  logic latch_q;
  logic clear_q;
  logic oe_n_q;
  spd_chan_t oc_q;
  spd_chan_t low_q;
  logic trip_q;
  logic release_q;

  // system state
  logic latch_prev;
  spd_chan_t storage;
  spd_word_t fault_word;
  spd_chan_t oc_flag;
  spd_chan_t os_flag;
  logic th_flag;
  logic th_active;
  spd_cnt_t base;
  logic reading;

  // next values
  logic latch_edge;
  spd_cnt_t fall_bin;
  spd_cnt_t index;
  spd_chan_t buffer_on;
  logic next_latch_prev;
  spd_chan_t next_storage;
  spd_word_t next_fault_word;
  spd_chan_t next_oc_flag;
  spd_chan_t next_os_flag;
  logic next_th_flag;
  logic next_th_active;
  spd_cnt_t next_base;
  logic next_reading;
  logic next_serial_out;
  spd_chan_t next_sink;
  spd_chan_t next_chop;

  // clear acts at once on the link side, even with the link clock stopped
  assign link_nrst = i_nrst & i_clear_all_n;

  spd_link u_link (
    .i_shift_clock(i_shift_clock),
    .i_link_nrst(link_nrst),
    .i_serial_in(i_serial_in),
    .o_shift_word(shift_word),
    .o_cascade_bit(cascade_bit),
    .o_fall_gray(fall_gray)
  );

  // shift word is quiet well before a latch edge, so per-bit sync is safe
  spd_sync #(.WIDTH(`SPD_CHANNELS)) u_sync_word (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_async(shift_word),
    .o_sync(shift_word_q)
  );

  spd_sync #(.WIDTH(`SPD_CNT_BITS)) u_sync_count (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_async(fall_gray),
    .o_sync(fall_gray_q)
  );

  spd_sync #(.WIDTH(4)) u_sync_ctl (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_async({cascade_bit, i_latch_clock, i_clear_all_n, i_output_enable_n}),
    .o_sync({cascade_q, latch_q, clear_q, oe_n_q})
  );

  spd_sync #(.WIDTH(2 * `SPD_CHANNELS + 2)) u_sync_sense (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_async({i_overcurrent, i_below_load_detect, i_temp_over_trip, i_temp_below_release}),
    .o_sync({oc_q, low_q, trip_q, release_q})
  );

  // latch strobe rise, seen only after its synchroniser
  always_comb
  begin
    latch_edge = latch_q & ~latch_prev;
    next_latch_prev = latch_q;
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      latch_prev <= 1'b0;
    end
    else
    begin
      latch_prev <= next_latch_prev;
    end
  end

  // hysteresis: stays tripped until the release comparator says cool
  always_comb
  begin
    next_th_active = th_active;
    if (trip_q)
    begin
      next_th_active = 1'b1;
    end
    else if (release_q)
    begin
      next_th_active = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      th_active <= 1'b0;
    end
    else
    begin
      th_active <= next_th_active;
    end
  end

  // flags handed to the readback word are spent; a new event still wins
  always_comb
  begin
    buffer_on = o_sink_channel_outputs;
    next_oc_flag = oc_flag;
    next_os_flag = os_flag;
    next_th_flag = th_flag;
    if (latch_edge)
    begin
      next_oc_flag = '0;
      next_os_flag = '0;
      next_th_flag = 1'b0;
    end
    next_oc_flag = next_oc_flag | (buffer_on & oc_q);
    next_os_flag = next_os_flag | (buffer_on & low_q);
    next_th_flag = next_th_flag | next_th_active;
    if (!clear_q)
    begin
      next_oc_flag = '0;
      next_os_flag = '0;
      next_th_flag = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      oc_flag <= '0;
      os_flag <= '0;
      th_flag <= 1'b0;
    end
    else
    begin
      oc_flag <= next_oc_flag;
      os_flag <= next_os_flag;
      th_flag <= next_th_flag;
    end
  end

  // storage and buffers; thermal trip overrides the enable
  always_comb
  begin
    next_storage = storage;
    if (latch_edge)
    begin
      next_storage = shift_word_q;
    end
    if (oe_n_q || next_th_active)
    begin
      next_sink = '0;
    end
    else
    begin
      next_sink = next_storage;
    end
    // chopping keeps the channel bit set; only the indicator shows it
    next_chop = next_sink & oc_q;
    if (!clear_q)
    begin
      next_storage = `SPD_CFG_RESET;
      next_sink = '0;
      next_chop = '0;
    end
  end

  // shift word is never written here, so readback leaves the config intact
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      storage <= `SPD_CFG_RESET;
      o_sink_channel_outputs <= '0;
      o_chop_active <= '0;
    end
    else
    begin
      storage <= next_storage;
      o_sink_channel_outputs <= next_sink;
      o_chop_active <= next_chop;
    end
  end

  // readback path: index counts falling edges since the load; msb first
  always_comb
  begin
    fall_bin = spd_gray2bin(fall_gray_q);
    index = fall_bin - base;
    next_fault_word = fault_word;
    next_base = base;
    next_reading = reading;
    if (latch_edge)
    begin
      next_fault_word = '0;
      next_fault_word[`SPD_FAULT_OC_MSB:`SPD_FAULT_OC_LSB] = oc_flag;
      next_fault_word[`SPD_FAULT_OS_MSB:`SPD_FAULT_OS_LSB] = os_flag;
      next_fault_word[`SPD_FAULT_RSV_BIT] = 1'b0;
      next_fault_word[`SPD_FAULT_TH_BIT] = th_flag;
      next_fault_word[`SPD_FAULT_CRC_MSB:0] = spd_crc(shift_word_q);
      next_base = fall_bin;
      next_reading = 1'b1;
    end
    else if (reading && index >= `SPD_FAULT_LAST)
    begin
      next_reading = 1'b0;
    end
    // once the word is out, the cascade bit follows for downstream devices
    if (next_reading)
    begin
      if (latch_edge)
      begin
        next_serial_out = next_fault_word[`SPD_FAULT_OC_MSB];
      end
      else
      begin
        next_serial_out = fault_word[5'(`SPD_FAULT_OC_MSB) - index];
      end
    end
    else
    begin
      next_serial_out = cascade_q;
    end
    if (!clear_q)
    begin
      next_fault_word = `SPD_FAULT_RESET;
      next_reading = 1'b0;
      next_serial_out = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      fault_word <= `SPD_FAULT_RESET;
      base <= '0;
      reading <= 1'b0;
      o_serial_out <= 1'b0;
    end
    else
    begin
      fault_word <= next_fault_word;
      base <= next_base;
      reading <= next_reading;
      o_serial_out <= next_serial_out;
    end
  end
endmodule
`default_nettype wire

// [spd_top_assertions.sv]
// checker for spd_top: outputs against pin levels and their sync delays
// assumes all pins are held as levels across several system clocks
`timescale 1ns/10ps
`default_nettype none
`include "spd_map.svh"
module spd_top_assertions
  import spd_pkg::*;
(
  // watched pins
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_shift_clock,
  input wire logic i_serial_in,
  input wire logic i_latch_clock,
  input wire logic i_clear_all_n,
  input wire logic i_output_enable_n,
  input wire logic o_serial_out,
  input wire spd_chan_t o_sink_channel_outputs,
  input wire spd_chan_t o_chop_active,
  input wire logic [`SPD_CHANNELS-1:0] i_overcurrent,
  input wire logic [`SPD_CHANNELS-1:0] i_below_load_detect,
  input wire logic i_temp_over_trip,
  input wire logic i_temp_below_release
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  a_reset_zero:
    assert property ($rose(i_nrst) |-> o_sink_channel_outputs == '0 && !o_serial_out)
    else $error("outputs not zero after reset");
  a_clear_zero:
    assert property (!i_clear_all_n [*5] |-> o_sink_channel_outputs == '0 && o_chop_active == '0)
    else $error("outputs not cleared");
  a_enable_off:
    assert property (i_output_enable_n [*5] |-> o_sink_channel_outputs == '0)
    else $error("outputs on while disabled");
  a_trip_off:
    assert property (i_temp_over_trip [*5] |-> o_sink_channel_outputs == '0)
    else $error("outputs on while tripped");
  a_sink_hold:
    assert property ((!i_output_enable_n && i_clear_all_n && !i_temp_over_trip && !i_latch_clock
      && $stable(i_temp_below_release)) [*6] |-> $stable(o_sink_channel_outputs))
    else $error("outputs changed without cause");
  a_serial_hold:
    assert property ((!i_latch_clock && $stable(i_shift_clock) && i_clear_all_n) [*7]
      |-> $stable(o_serial_out))
    else $error("serial out changed without edge");
  a_chop_on_only:
    assert property (o_chop_active != '0 |->
      (o_chop_active & ~(o_sink_channel_outputs | $past(o_sink_channel_outputs))) == '0)
    else $error("chop on a channel that is off");
  a_chop_cause:
    assert property (o_chop_active != '0 |-> (o_chop_active & ~($past(i_overcurrent, 2)
      | $past(i_overcurrent, 3) | $past(i_overcurrent, 4))) == '0)
    else $error("chop without overcurrent");
endmodule
bind spd_top spd_top_assertions i_spd_top_assertions (.*);
`default_nettype wire

// [spd_host.sv]
// host model: shifts a byte in, latches, reads the 24-bit fault word
// assumes a free 15 ns base clock; shift clock idles low between frames
`timescale 1ns/10ps
`default_nettype none
module spd_host
(
  // control from the bench
  input wire logic i_base_clock,
  input wire logic i_go,
  input wire logic [7:0] i_data,
  input wire logic i_serial_out,
  // device pins and result
  output logic o_shift_clock,
  output logic o_serial_in,
  output logic o_latch_clock,
  output logic [23:0] o_rdata,
  output logic o_done
);
  task automatic tick(input int n);
    repeat (n) @(posedge i_base_clock);
  endtask
  initial
  begin
    o_shift_clock = 1'b0;
    o_serial_in = 1'b0;
    o_latch_clock = 1'b0;
    o_rdata = 24'h000000;
    o_done = 1'b1;
  end
  always
  begin
    @(posedge i_go);
    o_done = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      o_serial_in = i_data[i];
      tick(4);
      o_shift_clock = 1'b1;
      tick(4);
      o_shift_clock = 1'b0;
    end
    tick(16); // 300 ns from last rise keeps the word whole
    o_latch_clock = 1'b1;
    tick(16);
    o_rdata[23] = i_serial_out;
    o_latch_clock = 1'b0;
    for (int k = 22; k >= 0; k--)
    begin
      o_serial_in = ~o_serial_in;
      o_shift_clock = 1'b1;
      tick(4);
      o_shift_clock = 1'b0;
      tick(4);
      o_rdata[k] = i_serial_out;
    end
    o_done = 1'b1;
  end
endmodule
`default_nettype wire

// [spd_top_tb.sv]
// self-checking bench for spd_top with a host model on the serial pins
// assumes the checker is bound from its own file
`timescale 1ns/10ps
`default_nettype none
module spd_top_tb;
  import spd_pkg::*;
  logic clk, clk15, nrst, clr_n, oe_n, trip, rel, go, done, sck, sdi, lck, so;
  logic [7:0] oc, bld, data, d, m, b;
  logic [23:0] rdata;
  logic [31:0] seed;
  spd_chan_t sinks, chop;
  int failures, n_tests;
  spd_top i_spd_top (.i_clock(clk), .i_nrst(nrst), .i_shift_clock(sck), .i_serial_in(sdi),
    .i_latch_clock(lck), .i_clear_all_n(clr_n), .i_output_enable_n(oe_n), .o_serial_out(so),
    .o_sink_channel_outputs(sinks), .o_chop_active(chop), .i_overcurrent(oc),
    .i_below_load_detect(bld), .i_temp_over_trip(trip), .i_temp_below_release(rel));
  spd_host i_spd_host (.i_base_clock(clk15), .i_go(go), .i_data(data), .i_serial_out(so),
    .o_shift_clock(sck), .o_serial_in(sdi), .o_latch_clock(lck), .o_rdata(rdata), .o_done(done));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // bitwise long division, separate from the design's own
  function automatic logic [5:0] crc_ref(input logic [13:0] v);
    for (int i = 13; i >= 6; i--)
      if (v[i])
        v = v ^ (14'h0043 << (i - 6));
    return v[5:0];
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic frame(input logic [7:0] v);
    int t;
    data = v;
    go = 1'b1;
    wt(4);
    go = 1'b0;
    for (t = 0; t < 2000 && done !== 1'b1; t++)
      @(negedge clk);
    if (t == 2000)
      failures++;
    wt(2);
  endtask
  function automatic logic [23:0] word(input logic [7:0] c, input logic [15:0] f, input logic t);
    return {f, 1'b0, t, crc_ref({c, 6'h00})};
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    clk15 = 1'b0;
    #3.7;
    forever #7.5 clk15 = ~clk15;
  end
  initial
  begin
    #200000;
    failures++;
    stop_test();
  end
  initial
  begin
    {nrst, clr_n, trip, go, data, oc, bld} = '0;
    {oe_n, rel} = 2'b11;
    failures = 0;
    n_tests = 0;
    seed = 32'hb7a2cc60;
    wt(3);
    nrst = 1'b1;
    wt(6);
    chk(sinks, 0);
    clr_n = 1'b1;
    oe_n = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : (i == 2) ? 8'h81 : seed[7:0];
      frame(d);
      chk(sinks, d);
      chk(rdata, word(d, 16'h0000, 1'b0));
      chk(crc_ref({d, rdata[5:0]}), 0);
      if (i == 0)
        chk(rdata[5:0], 6'h0D);
    end
    oe_n = 1'b1;
    wt(6);
    chk(sinks, 0);
    oe_n = 1'b0;
    wt(6);
    chk(sinks, d);
    seed = xs(seed);
    m = seed[7:0];
    b = seed[15:8];
    oc = m;
    bld = b;
    wt(10);
    chk(chop, m & d);
    chk(sinks, d);
    // first readback while current settles is thrown away
    frame(d);
    oc = 8'h00;
    bld = 8'h00;
    wt(10);
    frame(d);
    chk(rdata, word(d, {m & d, b & d}, 1'b0));
    frame(d);
    chk(rdata, word(d, 16'h0000, 1'b0));
    d = d | 8'h01;
    frame(d);
    trip = 1'b1;
    rel = 1'b0;
    wt(6);
    chk(sinks, 0);
    frame(d);
    chk(sinks, 0);
    trip = 1'b0;
    rel = 1'b1;
    wt(6);
    chk(sinks, d);
    frame(d);
    chk(rdata, word(d, 16'h0000, 1'b1));
    frame(d);
    chk(rdata, word(d, 16'h0000, 1'b0));
    clr_n = 1'b0;
    wt(6);
    chk(sinks, 0);
    clr_n = 1'b1;
    wt(6);
    chk(sinks, 0);
    frame(d);
    chk(sinks, d);
    stop_test();
  end
endmodule
`default_nettype wire
